/* inc/hvmb_pkg.sv */
// What this block does
// - Function codes 03 and 04 both read the same register map.
// - Writes are taken only through function codes 06 and 16.
// - Register words other than energy values go out high byte first unless configured low byte first.
// - Unsupported function or bad address gets a standard exception answer.
// - Serial rates 1200 to 56700 baud, eight data bits, no parity, one stop.
// - Serial answers only its configured slave address; phy type is selectable.
// - TCP requests are served only on the configured port, default 502.
// - At most two TCP masters and one serial master are served.
// - Up to 128 indoor units, fifteen points each.
// - Addresses 1 and 2 read adaptor link status codes 0 to 259.
// - Addresses 3-8 and 15 write-only group commands; 9-14 read/write settings.
// - Setpoints accept -15..60 Celsius or 5..140 Fahrenheit.
// - Group fan value 1 low, 2 medium, 3 high, 4 automatic.
// - Writing 1 to address 15 clears the energy counters.
// - Handset lock 1..31 is a bitmask: power, mode, setpoint, louver, fan.
// - Unit n registers sit at n times 20 plus offset 1 to 18.
// - Presence reads 0 absent, 1 present.
// - Unit power reads and accepts 0 off, 1 on.
// - Energy yesterday, today, total sit at offsets 13, 15 and 17.
// - Louver direction does not apply to ventilation-only units.
// - Polled unit states are stored and reads are served from the store.
// - A good write forwards a command to the matching unit signal.
// - A unit that does not answer a poll gets a communication-error flag.
// - 32-bit values use byte order b3b2b1b0, b0b1b2b3 or b2b3b0b1.
package hvmb_pkg;
  localparam int          CLK_HZ         = 20000000;
  localparam logic [7:0]  FN_RD_HOLD     = 8'h03;
  localparam logic [7:0]  FN_RD_INPUT    = 8'h04;
  localparam logic [7:0]  FN_WR_SINGLE   = 8'h06;
  localparam logic [7:0]  FN_WR_MULTI    = 8'h10;
  localparam logic [7:0]  EXC_NONE       = 8'h00;
  localparam logic [7:0]  EXC_ILL_FUNC   = 8'h01;
  localparam logic [7:0]  EXC_ILL_ADDR   = 8'h02;
  localparam logic [7:0]  EXC_ILL_VALUE  = 8'h03;
  localparam logic [7:0]  EXC_BUSY       = 8'h06;
  localparam logic [1:0]  SRC_SERIAL     = 2'h0;
  localparam logic [1:0]  SRC_TCP_LAST   = 2'h2;
  localparam logic [15:0] TCP_PORT_DFLT  = 16'h01F6;
  localparam logic [15:0] UNIT_STRIDE    = 16'h0014;
  localparam logic [7:0]  UNIT_MAX       = 8'h80;
  localparam logic [4:0]  ADDR_LINK_ONE  = 5'h01;
  localparam logic [4:0]  ADDR_LINK_TWO  = 5'h02;
  localparam logic [4:0]  ADDR_GRP_POWER = 5'h03;
  localparam logic [4:0]  ADDR_GRP_MODE  = 5'h04;
  localparam logic [4:0]  ADDR_GRP_SETPT = 5'h05;
  localparam logic [4:0]  ADDR_GRP_FAN   = 5'h06;
  localparam logic [4:0]  ADDR_GRP_LOCK  = 5'h07;
  localparam logic [4:0]  ADDR_GRP_PRES  = 5'h08;
  localparam logic [4:0]  ADDR_GRP_RW_LO = 5'h09;
  localparam logic [4:0]  ADDR_GRP_RW_HI = 5'h0E;
  localparam logic [4:0]  ADDR_EN_CLEAR  = 5'h0F;
  localparam logic [4:0]  OFF_PRESENT    = 5'h01;
  localparam logic [4:0]  OFF_POWER      = 5'h02;
  localparam logic [4:0]  OFF_MODE       = 5'h03;
  localparam logic [4:0]  OFF_SETPT      = 5'h04;
  localparam logic [4:0]  OFF_ROOM_TEMP  = 5'h05;
  localparam logic [4:0]  OFF_FAN        = 5'h06;
  localparam logic [4:0]  OFF_LOUVER     = 5'h07;
  localparam logic [4:0]  OFF_FILT_ALARM = 5'h08;
  localparam logic [4:0]  OFF_FILT_CLEAR = 5'h09;
  localparam logic [4:0]  OFF_FAULT      = 5'h0A;
  localparam logic [4:0]  OFF_LOCK       = 5'h0B;
  localparam logic [4:0]  OFF_PRESENCE   = 5'h0C;
  localparam logic [4:0]  OFF_EN_YEST    = 5'h0D;
  localparam logic [4:0]  OFF_EN_TODAY   = 5'h0F;
  localparam logic [4:0]  OFF_EN_TOTAL   = 5'h11;
  localparam logic [4:0]  OFF_EN_LAST    = 5'h12;
  localparam logic [15:0] SP_C_MIN       = 16'hFFF1;
  localparam logic [15:0] SP_C_MAX       = 16'h003C;
  localparam logic [15:0] SP_F_MIN       = 16'h0005;
  localparam logic [15:0] SP_F_MAX       = 16'h008C;
  localparam logic [15:0] FAN_MIN        = 16'h0001;
  localparam logic [15:0] FAN_MAX        = 16'h0004;
  localparam logic [15:0] LOCK_MIN       = 16'h0001;
  localparam logic [15:0] LOCK_MAX       = 16'h001F;
  localparam int          LOCK_POWER_BIT = 0;
  localparam int          LOCK_MODE_BIT  = 1;
  localparam int          LOCK_SETPT_BIT = 2;
  localparam int          LOCK_LOUVER_BIT = 3;
  localparam int          LOCK_FAN_BIT   = 4;
  localparam logic [15:0] COMM_ERR_CODE  = 16'h00FF;
  localparam int          BAUD_1200      = 1200;
  localparam int          BAUD_2400      = 2400;
  localparam int          BAUD_4800      = 4800;
  localparam int          BAUD_9600      = 9600;
  localparam int          BAUD_19200     = 19200;
  localparam int          BAUD_38400     = 38400;
  localparam int          BAUD_56700     = 56700;
  localparam logic [15:0] DIV_1200       = 16'(CLK_HZ / BAUD_1200);
  localparam logic [15:0] DIV_2400       = 16'(CLK_HZ / BAUD_2400);
  localparam logic [15:0] DIV_4800       = 16'(CLK_HZ / BAUD_4800);
  localparam logic [15:0] DIV_9600       = 16'(CLK_HZ / BAUD_9600);
  localparam logic [15:0] DIV_19200      = 16'(CLK_HZ / BAUD_19200);
  localparam logic [15:0] DIV_38400      = 16'(CLK_HZ / BAUD_38400);
  localparam logic [15:0] DIV_56700      = 16'(CLK_HZ / BAUD_56700);
  localparam logic [3:0]  SER_DATA_BITS  = 4'h8;
  localparam logic [1:0]  SER_STOP_BITS  = 2'h1;
  localparam logic [1:0]  ORD_B3B2B1B0   = 2'h0;
  localparam logic [1:0]  ORD_B0B1B2B3   = 2'h1;
  localparam logic [1:0]  ORD_B1B0B3B2   = 2'h2;
endpackage

/* hdl/hvmb_regmap.sv */
`timescale 1ns/1ps
module hvmb_regmap
  import hvmb_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        arst_n,
  // Configuration
  input  wire logic        cfg_lsb_first,
  input  wire logic [1:0]  cfg_word_order,
  input  wire logic        cfg_fahrenheit,
  input  wire logic [7:0]  cfg_slave_addr,
  input  wire logic [15:0] cfg_tcp_port,
  input  wire logic [2:0]  cfg_baud_sel,
  input  wire logic        cfg_phy_diff,
  // Adaptor link status
  input  wire logic [15:0] link_one_code,
  input  wire logic [15:0] link_two_code,
  // Register request, one register per request
  input  wire logic        req_valid,
  input  wire logic [1:0]  req_src,
  input  wire logic [7:0]  req_slave,
  input  wire logic [15:0] req_port,
  input  wire logic [7:0]  req_func,
  input  wire logic [15:0] req_addr,
  input  wire logic [15:0] req_wdata,
  // Register answer
  output logic             rsp_valid,
  output logic [1:0]       rsp_src,
  output logic [7:0]       rsp_exc,
  output logic [15:0]      rsp_data,
  // Poll results from the adaptor side
  input  wire logic        upd_valid,
  input  wire logic [7:0]  upd_unit,
  input  wire logic [4:0]  upd_off,
  input  wire logic [31:0] upd_data,
  input  wire logic        upd_vent,
  input  wire logic        upd_noresp,
  // Commands toward the adaptor, unit 0 means all units
  output logic             cmd_valid,
  output logic [7:0]       cmd_unit,
  output logic [4:0]       cmd_field,
  output logic [15:0]      cmd_value,
  output logic [4:0]       cmd_lock,
  // Serial port settings
  output logic [15:0]      baud_div,
  output logic             differential_serial_phy,
  output logic [3:0]       ser_data_bits,
  output logic [1:0]       ser_stop_bits
);

  function automatic logic [15:0] swap16(input logic [15:0] w, input logic en);
    swap16 = en ? {w[7:0], w[15:8]} : w;
  endfunction

  function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = ($signed(v) >= $signed(lo)) && ($signed(v) <= $signed(hi));
  endfunction

  // Polled store; unit n lives at index n-1
  logic [15:0] unit_mem   [0:4095];
  // Four slots per unit so the index is a plain concatenation; slot 3 unused
  logic [31:0] energy_mem [0:511];
  logic [127:0] vent_reg;
  logic [127:0] comm_err_reg;
  logic [127:0] energy_ok_reg;
  logic [15:0]  group_reg [0:5];

  logic [15:0] unit_q;
  logic [15:0] off_q;
  logic [7:0]  unit_n;
  logic [4:0]  off_n;
  logic [6:0]  uidx;
  logic        ign_c;
  logic        is_rd;
  logic        is_wr;
  logic        sp_ok;
  logic [7:0]  exc_c;
  logic [15:0] rd_c;
  logic [15:0] wval;
  logic        cmd_c;
  logic [31:0] en_word;
  logic [31:0] en_ord;
  logic [8:0]  en_idx;
  logic        clear_c;
  logic        grp_wr_c;
  logic [6:0]  upd_idx;

  assign unit_q  = req_addr / UNIT_STRIDE;
  assign off_q   = req_addr % UNIT_STRIDE;
  assign unit_n  = unit_q[7:0];
  assign off_n   = off_q[4:0];
  assign uidx    = 7'(unit_n - 8'h01);
  assign upd_idx = 7'(upd_unit - 8'h01);
  assign wval    = swap16(req_wdata, cfg_lsb_first);
  assign sp_ok   = cfg_fahrenheit ? in_range(wval, SP_F_MIN, SP_F_MAX)
                                  : in_range(wval, SP_C_MIN, SP_C_MAX);
  assign is_rd   = (req_func == FN_RD_HOLD) || (req_func == FN_RD_INPUT);
  assign is_wr   = (req_func == FN_WR_SINGLE) || (req_func == FN_WR_MULTI);
  // Requests not meant for this slave or port get no answer at all
  assign ign_c   = (req_src == SRC_SERIAL) ? (req_slave != cfg_slave_addr)
                                           : (req_port != cfg_tcp_port);
  assign en_idx  = (off_n < OFF_EN_TODAY) ? {uidx, 2'h0} :
                   (off_n < OFF_EN_TOTAL) ? {uidx, 2'h1} : {uidx, 2'h2};
  assign en_word = energy_ok_reg[uidx] ? energy_mem[en_idx] : 32'h0;

  // 32-bit values: word pair order follows the configured byte order
  always_comb begin
    unique case (cfg_word_order)
      ORD_B0B1B2B3: en_ord = {en_word[7:0], en_word[15:8], en_word[23:16], en_word[31:24]};
      ORD_B1B0B3B2: en_ord = {en_word[23:16], en_word[31:24], en_word[7:0], en_word[15:8]};
      default:      en_ord = en_word;
    endcase
  end

  always_comb begin
    exc_c    = EXC_NONE;
    rd_c     = 16'h0000;
    cmd_c    = 1'b0;
    clear_c  = 1'b0;
    grp_wr_c = 1'b0;
    if (req_src > SRC_TCP_LAST) begin
      exc_c = EXC_BUSY;
    end else if (!is_rd && !is_wr) begin
      exc_c = EXC_ILL_FUNC;
    end else if (unit_n == 8'h00) begin
      if (off_n == ADDR_LINK_ONE || off_n == ADDR_LINK_TWO) begin
        if (is_wr) begin
          exc_c = EXC_ILL_ADDR;
        end else begin
          rd_c = swap16((off_n == ADDR_LINK_ONE) ? link_one_code : link_two_code,
                        cfg_lsb_first);
        end
      end else if (off_n >= ADDR_GRP_RW_LO && off_n <= ADDR_GRP_RW_HI) begin
        if (is_rd) begin
          rd_c = swap16(group_reg[3'(off_n - ADDR_GRP_RW_LO)], cfg_lsb_first);
        end else if (off_n <= 5'h0C && !sp_ok) begin
          exc_c = EXC_ILL_VALUE;
        end else begin
          grp_wr_c = 1'b1;
          cmd_c    = 1'b1;
        end
      end else if (off_n >= ADDR_GRP_POWER && off_n <= ADDR_EN_CLEAR) begin
        if (is_rd) begin
          exc_c = EXC_ILL_ADDR;
        end else if (off_n == ADDR_GRP_SETPT && !sp_ok) begin
          exc_c = EXC_ILL_VALUE;
        end else if (off_n == ADDR_GRP_FAN && !in_range(wval, FAN_MIN, FAN_MAX)) begin
          exc_c = EXC_ILL_VALUE;
        end else if (off_n == ADDR_GRP_LOCK && !in_range(wval, LOCK_MIN, LOCK_MAX)) begin
          exc_c = EXC_ILL_VALUE;
        end else begin
          cmd_c   = 1'b1;
          clear_c = (off_n == ADDR_EN_CLEAR) && (wval == 16'h0001);
        end
      end else begin
        exc_c = EXC_ILL_ADDR;
      end
    end else if (unit_n > UNIT_MAX || off_n == 5'h00 || off_n > OFF_EN_LAST) begin
      exc_c = EXC_ILL_ADDR;
    end else begin
      unique case (off_n)
        OFF_PRESENT, OFF_ROOM_TEMP, OFF_FILT_ALARM: begin
          if (is_wr) exc_c = EXC_ILL_ADDR;
          else rd_c = swap16(unit_mem[{uidx, off_n}], cfg_lsb_first);
        end
        OFF_FILT_CLEAR: begin
          if (is_rd) exc_c = EXC_ILL_ADDR;
          else cmd_c = 1'b1;
        end
        OFF_EN_YEST, 5'h0E, OFF_EN_TODAY, 5'h10, OFF_EN_TOTAL, OFF_EN_LAST: begin
          if (is_wr) begin
            exc_c = EXC_ILL_ADDR;
          end else if (off_n[0]) begin
            rd_c = en_ord[31:16];
          end else begin
            rd_c = en_ord[15:0];
          end
        end
        OFF_LOUVER: begin
          if (vent_reg[uidx]) exc_c = EXC_ILL_ADDR;
          else if (is_rd) rd_c = swap16(unit_mem[{uidx, off_n}], cfg_lsb_first);
          else cmd_c = 1'b1;
        end
        OFF_FAULT: begin
          if (is_wr) begin
            cmd_c = 1'b1;
          end else begin
            rd_c = swap16(comm_err_reg[uidx] ? COMM_ERR_CODE : unit_mem[{uidx, off_n}],
                          cfg_lsb_first);
          end
        end
        default: begin
          if (is_rd) begin
            rd_c = swap16(unit_mem[{uidx, off_n}], cfg_lsb_first);
          end else if (off_n == OFF_POWER && wval > 16'h0001) begin
            exc_c = EXC_ILL_VALUE;
          end else if (off_n == OFF_SETPT && !sp_ok) begin
            exc_c = EXC_ILL_VALUE;
          end else if (off_n == OFF_LOCK && !in_range(wval, LOCK_MIN, LOCK_MAX)) begin
            exc_c = EXC_ILL_VALUE;
          end else begin
            cmd_c = 1'b1;
          end
        end
      endcase
    end
  end

  // Answer, one cycle after the request
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_valid <= 1'b0;
      rsp_src   <= 2'h0;
      rsp_exc   <= EXC_NONE;
      rsp_data  <= 16'h0000;
    end else begin
      rsp_valid <= req_valid && !ign_c;
      if (req_valid && !ign_c) begin
        rsp_src  <= req_src;
        rsp_exc  <= exc_c;
        rsp_data <= (exc_c == EXC_NONE) ? rd_c : 16'h0000;
      end
    end
  end

  // Command forwarding
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_valid <= 1'b0;
      cmd_unit  <= 8'h00;
      cmd_field <= 5'h00;
      cmd_value <= 16'h0000;
      cmd_lock  <= 5'h00;
    end else begin
      cmd_valid <= req_valid && !ign_c && cmd_c && (exc_c == EXC_NONE);
      if (req_valid && !ign_c && cmd_c) begin
        cmd_unit  <= unit_n;
        cmd_field <= off_n;
        cmd_value <= wval;
        cmd_lock  <= wval[4:0];
      end
    end
  end

  // Group settings kept locally so they read back
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 6; i++) group_reg[i] <= 16'h0000;
    end else if (req_valid && !ign_c && grp_wr_c) begin
      group_reg[3'(off_n - ADDR_GRP_RW_LO)] <= wval;
    end
  end

  // Poll store, no reset: contents are meaningless until polled
  always_ff @(posedge mclk) begin
    if (upd_valid && !upd_noresp && upd_unit != 8'h00 && upd_unit <= UNIT_MAX) begin
      unit_mem[{upd_idx, upd_off}] <= upd_data[15:0];
      if (upd_off == OFF_EN_YEST) energy_mem[{upd_idx, 2'h0}] <= upd_data;
      if (upd_off == OFF_EN_TODAY) energy_mem[{upd_idx, 2'h1}] <= upd_data;
      if (upd_off == OFF_EN_TOTAL) energy_mem[{upd_idx, 2'h2}] <= upd_data;
    end
  end

  // Per-unit flags; a fresh update wins over a clear in the same cycle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      vent_reg      <= '0;
      comm_err_reg  <= '0;
      energy_ok_reg <= '0;
    end else begin
      if (req_valid && !ign_c && clear_c && exc_c == EXC_NONE) begin
        energy_ok_reg <= '0;
      end
      if (upd_valid && upd_unit != 8'h00 && upd_unit <= UNIT_MAX) begin
        comm_err_reg[upd_idx] <= upd_noresp;
        if (!upd_noresp) begin
          vent_reg[upd_idx] <= upd_vent;
          if (upd_off >= OFF_EN_YEST && upd_off <= OFF_EN_LAST) energy_ok_reg[upd_idx] <= 1'b1;
        end
      end
    end
  end

  // Serial settings; an unused select code falls back to 9600
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      baud_div                <= DIV_9600;
      differential_serial_phy <= 1'b0;
      ser_data_bits           <= SER_DATA_BITS;
      ser_stop_bits           <= SER_STOP_BITS;
    end else begin
      differential_serial_phy <= cfg_phy_diff;
      ser_data_bits           <= SER_DATA_BITS;
      ser_stop_bits           <= SER_STOP_BITS;
      unique case (cfg_baud_sel)
        3'h0:    baud_div <= DIV_1200;
        3'h1:    baud_div <= DIV_2400;
        3'h2:    baud_div <= DIV_4800;
        3'h3:    baud_div <= DIV_9600;
        3'h4:    baud_div <= DIV_19200;
        3'h5:    baud_div <= DIV_38400;
        3'h6:    baud_div <= DIV_56700;
        default: baud_div <= DIV_9600;
      endcase
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);

  a_answer_timing: assert property (req_valid && !ign_c |=> rsp_valid)
    else $error("accepted request not answered next cycle");
  a_ignored_silent: assert property (req_valid && ign_c |=> !rsp_valid)
    else $error("request for other slave or port answered");
  a_bad_function: assert property (req_valid && !ign_c && req_src <= SRC_TCP_LAST && !is_rd
                                    && !is_wr |=> rsp_exc == EXC_ILL_FUNC)
    else $error("unsupported function not refused");
  a_extra_master: assert property (req_valid && !ign_c && req_src == 2'h3
                                   |=> rsp_exc == EXC_BUSY)
    else $error("fourth master served");
  a_wo_read_fail: assert property (req_valid && !ign_c && is_rd && req_src != 2'h3
                                   && req_addr == 16'h000F |=> rsp_exc == EXC_ILL_ADDR)
    else $error("write-only register read without exception");
  a_link_readback: assert property (req_valid && !ign_c && is_rd && req_src != 2'h3
                                    && req_addr == 16'h0001 |=> rsp_exc == EXC_NONE &&
                                    rsp_data == swap16($past(link_one_code),
                                                       $past(cfg_lsb_first)))
    else $error("link status readback wrong");
  a_fan_range: assert property (req_valid && !ign_c && is_wr && req_src != 2'h3
                                && req_addr == 16'h0006 && wval == 16'h0005
                                |=> rsp_exc == EXC_ILL_VALUE && !cmd_valid)
    else $error("fan value 5 accepted");
  a_unit_limit: assert property (req_valid && !ign_c && req_src != 2'h3 && (is_rd || is_wr)
                                 && req_addr == 16'h0A15 |=> rsp_exc == EXC_ILL_ADDR)
    else $error("unit 129 accepted");
  a_cmd_pairs_ok: assert property (cmd_valid |-> rsp_valid && rsp_exc == EXC_NONE
                                   && cmd_lock == cmd_value[4:0])
    else $error("command forwarded without clean answer");
  a_clear_energy: assert property (req_valid && !ign_c && clear_c && exc_c == EXC_NONE
                                   && !upd_valid |=> energy_ok_reg == '0)
    else $error("energy counters not cleared");

endmodule

/* bench/hvmb_master.sv */
`timescale 1ns/1ps
module hvmb_master
  import hvmb_pkg::*;
(
  // Clock
  input  wire logic        mclk,
  // Request toward the register map
  output logic             req_valid,
  output logic [1:0]       req_src,
  output logic [7:0]       req_slave,
  output logic [15:0]      req_port,
  output logic [7:0]       req_func,
  output logic [15:0]      req_addr,
  output logic [15:0]      req_wdata,
  // Answer
  input  wire logic        rsp_valid,
  input  wire logic [7:0]  rsp_exc,
  input  wire logic [15:0] rsp_data
);
  initial begin
    req_valid = 1'b0;
    req_src   = SRC_SERIAL;
    req_slave = 8'h00;
    req_port  = TCP_PORT_DFLT;
    req_func  = FN_RD_HOLD;
    req_addr  = 16'h0000;
    req_wdata = 16'h0000;
  end
  // Single register per request, read 03/04, write 06/10h
  task automatic xfer(input logic [1:0] src, input logic [7:0] slv, input logic [7:0] fn,
                      input logic [15:0] adr, input logic [15:0] wd, output logic got,
                      output logic [7:0] exc, output logic [15:0] dat);
    @(posedge mclk) #2;
    req_valid = 1'b1;
    req_src   = src;
    req_slave = slv;
    req_func  = fn;
    req_addr  = adr;
    req_wdata = wd;
    @(posedge mclk) #1;
    got = rsp_valid;
    exc = rsp_exc;
    dat = rsp_data;
    #1;
    req_valid = 1'b0;
    // Released lines flip so stale values cannot pass
    req_addr  = ~adr;
    req_wdata = ~wd;
  endtask
endmodule

/* bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import hvmb_pkg::*;
  logic mclk, arst_n, lsb, fahr, upd_valid, upd_noresp, got, rsp_valid, cmd_valid;
  logic [1:0] word_ord, src, rsp_src;
  logic [7:0] upd_unit, exc, rsp_exc, cmd_unit, r_slave, r_func;
  logic [4:0] upd_off, cmd_field, cmd_lock;
  logic [15:0] dat, rsp_data, cmd_value, baud_div, r_port, r_addr, r_wdata;
  logic [31:0] upd_data;
  logic r_valid, vent, phy, phy_out;
  logic [1:0] r_src_w, stop_bits;
  logic [3:0] data_bits;
  int err_total, n_compared, cycles;
  hvmb_regmap uut (.mclk(mclk), .arst_n(arst_n), .cfg_lsb_first(lsb), .cfg_word_order(word_ord),
    .cfg_fahrenheit(fahr), .cfg_slave_addr(8'h11), .cfg_tcp_port(TCP_PORT_DFLT),
    .cfg_baud_sel(3'h3), .cfg_phy_diff(phy), .link_one_code(16'h0103),
    .link_two_code(16'h0100), .req_valid(r_valid), .req_src(r_src_w), .req_slave(r_slave),
    .req_port(r_port), .req_func(r_func), .req_addr(r_addr), .req_wdata(r_wdata),
    .rsp_valid(rsp_valid), .rsp_src(rsp_src), .rsp_exc(rsp_exc), .rsp_data(rsp_data),
    .upd_valid(upd_valid), .upd_unit(upd_unit), .upd_off(upd_off), .upd_data(upd_data),
    .upd_vent(vent), .upd_noresp(upd_noresp), .cmd_valid(cmd_valid), .cmd_unit(cmd_unit),
    .cmd_field(cmd_field), .cmd_value(cmd_value), .cmd_lock(cmd_lock), .baud_div(baud_div),
    .differential_serial_phy(phy_out), .ser_data_bits(data_bits),
    .ser_stop_bits(stop_bits));
  hvmb_master host (.mclk(mclk), .req_valid(r_valid), .req_src(r_src_w), .req_slave(r_slave),
    .req_port(r_port), .req_func(r_func), .req_addr(r_addr), .req_wdata(r_wdata),
    .rsp_valid(rsp_valid), .rsp_exc(rsp_exc), .rsp_data(rsp_data));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rq(input logic [7:0] fn, input logic [15:0] adr, input logic [15:0] wd);
    host.xfer(src, 8'h11, fn, adr, wd, got, exc, dat);
  endtask
  task automatic poll(input logic [7:0] u, input logic [4:0] o, input logic [31:0] d,
                      input logic nr);
    @(posedge mclk) #2;
    {upd_valid, upd_unit, upd_off, upd_data, upd_noresp} = {1'b1, u, o, d, nr};
    @(posedge mclk) #2;
    upd_valid = 1'b0;
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic t_status;
    chk("baud", baud_div, DIV_9600);
    chk("data bits", data_bits, SER_DATA_BITS);
    chk("stop bits", stop_bits, SER_STOP_BITS);
    chk("phy reset", phy_out, 1'b0);
    phy = 1'b1;
    rq(FN_RD_HOLD, 16'h0001, 16'h0);
    chk("link1", dat, 16'h0103);
    rq(FN_RD_INPUT, 16'h0002, 16'h0);
    chk("link2", dat, 16'h0100);
    lsb = 1'b1;
    rq(FN_RD_HOLD, 16'h0001, 16'h0);
    chk("swapped", dat, 16'h0301);
    chk("phy diff", phy_out, 1'b1);
    lsb = 1'b0;
    $display("status test done");
  endtask
  task automatic t_group;
    rq(FN_WR_SINGLE, 16'h0006, 16'h0002);
    chk("fan cmd", {cmd_valid, cmd_unit, cmd_field}, {1'b1, 8'h00, 5'h06});
    rq(FN_WR_SINGLE, 16'h0006, 16'h0005);
    chk("fan range", exc, EXC_ILL_VALUE);
    rq(FN_WR_SINGLE, 16'h0007, 16'h0014);
    chk("lock", cmd_lock, 16'h0014);
    rq(FN_WR_MULTI, 16'h0009, 16'hFFF1);
    rq(FN_RD_HOLD, 16'h0009, 16'h0);
    chk("group rw", dat, 16'hFFF1);
    rq(FN_WR_SINGLE, 16'h0005, 16'hFFF0);
    chk("setpoint low", exc, EXC_ILL_VALUE);
    fahr = 1'b1;
    rq(FN_WR_SINGLE, 16'h0005, 16'h008D);
    chk("setpoint f", exc, EXC_ILL_VALUE);
    fahr = 1'b0;
    rq(FN_RD_HOLD, 16'h0003, 16'h0);
    chk("read wo", exc, EXC_ILL_ADDR);
    rq(FN_WR_SINGLE, 16'h0001, 16'h0);
    chk("write ro", exc, EXC_ILL_ADDR);
    rq(8'h05, 16'h0001, 16'h0);
    chk("bad func", exc, EXC_ILL_FUNC);
    $display("group test done");
  endtask
  task automatic t_unit;
    poll(8'h01, OFF_POWER, 32'h1, 1'b0);
    rq(FN_RD_HOLD, 16'd22, 16'h0);
    chk("power", dat, 16'h0001);
    poll(8'h03, OFF_FAULT, 32'h0, 1'b1);
    rq(FN_RD_HOLD, 16'd70, 16'h0);
    chk("comm err", dat, COMM_ERR_CODE);
    poll(8'h02, OFF_EN_YEST, 32'h11223344, 1'b0);
    rq(FN_RD_HOLD, 16'd53, 16'h0);
    chk("energy hi", dat, 16'h1122);
    rq(FN_RD_HOLD, 16'd54, 16'h0);
    chk("energy lo", dat, 16'h3344);
    word_ord = ORD_B0B1B2B3;
    rq(FN_RD_HOLD, 16'd53, 16'h0);
    chk("energy swap", dat, 16'h4433);
    rq(FN_WR_SINGLE, 16'h000F, 16'h0001);
    rq(FN_RD_HOLD, 16'd53, 16'h0);
    chk("energy clear", dat, 16'h0000);
    rq(FN_RD_HOLD, 16'd2581, 16'h0);
    chk("unit 129", exc, EXC_ILL_ADDR);
    rq(FN_RD_HOLD, 16'd39, 16'h0);
    chk("gap", exc, EXC_ILL_ADDR);
    vent = 1'b1;
    poll(8'h04, OFF_LOUVER, 32'h1, 1'b0);
    vent = 1'b0;
    rq(FN_RD_HOLD, 16'd87, 16'h0);
    chk("vent louver", exc, EXC_ILL_ADDR);
    $display("unit test done");
  endtask
  task automatic t_masters;
    host.xfer(SRC_SERIAL, 8'h12, FN_RD_HOLD, 16'h0001, 16'h0, got, exc, dat);
    chk("other slave", got, 1'b0);
    src = 2'h3;
    rq(FN_RD_HOLD, 16'h0001, 16'h0);
    chk("third tcp", exc, EXC_BUSY);
    src = SRC_TCP_LAST;
    rq(FN_RD_HOLD, 16'h0001, 16'h0);
    chk("tcp ok", {got, exc}, {1'b1, EXC_NONE});
    chk("rsp src", rsp_src, SRC_TCP_LAST);
    $display("master test done");
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      end_sim;
    end
  end
  initial begin
    {arst_n, lsb, fahr, upd_valid, upd_noresp, word_ord, src, vent, phy} = '0;
    {upd_unit, upd_off, upd_data} = '0;
    repeat (8) @(posedge mclk);
    #2 arst_n = 1'b1;
    @(posedge mclk) #2;
    t_status;
    t_group;
    t_unit;
    t_masters;
    end_sim;
  end
endmodule
